// File: core/radio_pkt_core.sv
`timescale 1ns/10ps
// How it works
// - Toggling bit raises quality counter by one
// - Repeated bit lowers quality counter by eight
// - Sync accepted when counter reaches four times threshold
// - Trailer adds strength byte, then byte of checksum-good flag and quality
// - Filter mode picks own or broadcast addresses
// - Address compared against node id register
// - Whitening only while legacy checksum is off
// - Format two sends pseudo-random bits in transmit
// - Legacy checksum only while whitening is off
// - Checksum enable drives insertion and checking
// - Length from fixed register or first byte
// - Slot index times spacing added to base
// - Receive subtracts IF; IF drives mixer
// - Signed trim scaled and added to base
// - Base word over three registers, top read-only
// - Fixed length caps variable packet length
module radio_pkt_core
  import radio_pkt_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [17:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic rx_bit_valid_in,
  input wire logic rx_bit_in,
  input wire logic sync_seen_in,
  input wire logic rx_addr_valid_in,
  input wire logic [7:0] rx_addr_in,
  input wire logic rx_len_valid_in,
  input wire logic [7:0] rx_len_in,
  input wire logic [7:0] rssi_in,
  input wire logic [6:0] link_quality_value_in,
  input wire logic crc_ok_in,
  input wire logic tx_bit_strobe_in,
  input wire logic rx_mode_in,
  input wire logic [15:0] rf_slot_index_spacing_in,
  output logic sync_accept_out,
  output logic addr_valid_out,
  output logic addr_accept_out,
  output logic len_valid_out,
  output logic [7:0] len_out,
  output logic len_error_out,
  output logic trailer_enable_out,
  output logic [7:0] trailer_byte0_out,
  output logic [7:0] trailer_byte1_out,
  output logic whiten_active_out,
  output logic legacy_crc_out,
  output logic crc_enable_out,
  output logic random_tx_out,
  output logic pn9_bit_out,
  output logic [4:0] if_mixer_out,
  output logic [23:0] synth_word_out
);
  // Configuration fields
  logic [7:0] max_payload_size_q; // Fixed length or cap
  logic [2:0] preamble_quality_threshold_q;
  logic status_trailer_enable_q;
  logic [1:0] address_filter_mode_q;
  logic whitening_enable_q;
  logic [1:0] packet_format_select_q;
  logic legacy_checksum_mode_q;
  logic crc_en_q;
  logic [1:0] len_mode_q;
  logic [7:0] node_id_q;
  logic [7:0] rf_slot_index_q;
  logic if_rsvd_q; // Reserved bit, kept as storage
  logic [4:0] intermediate_base_carrier_word_word_q;
  logic [7:0] synth_offset_trim_q;
  logic [21:0] base_carrier_word_q; // Writable part of base word
  // Datapath state
  logic [4:0] pq_count_q; // Preamble quality counter
  logic last_bit_q; // Previous received bit
  logic have_bit_q; // A previous bit exists
  logic [8:0] pn9_q; // Pseudo-random shift register
  // Bus decode
  logic bus_req;
  logic bus_wr;
  logic [15:0] bus_idx;
  logic [7:0] rd_byte;
  logic [23:0] base_full;
  logic [4:0] pq_thr;
  logic [23:0] synth_d;
  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign bus_wr = bus_req & wb_we_in & wb_sel_in[0];
  assign bus_idx = wb_adr_in[17:2];
  assign base_full = {CARRIER_TOP_RO, base_carrier_word_q};
  assign pq_thr = {preamble_quality_threshold_q, {PQ_THR_SHIFT{1'b0}}};
  // Wishbone handshake, one wait state then ack
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
    end else if (ce_in) begin
      wb_ack_out <= bus_req;
    end
  end
  // Read mux; unmapped and unused bits give zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (bus_idx)
      IDX_PAYLOAD_LIMIT: rd_byte = max_payload_size_q;
      IDX_PKT_CTRL_A: rd_byte = {preamble_quality_threshold_q, 2'h0,
                                 status_trailer_enable_q, address_filter_mode_q};
      IDX_PKT_CTRL_B: rd_byte = {1'b0, whitening_enable_q, packet_format_select_q,
                                 legacy_checksum_mode_q, crc_en_q, len_mode_q};
      IDX_NODE_ID: rd_byte = node_id_q;
      IDX_SLOT_NUM: rd_byte = rf_slot_index_q;
      IDX_IF_CTRL: rd_byte = {2'h0, if_rsvd_q, intermediate_base_carrier_word_word_q};
      IDX_OFFSET_CTRL: rd_byte = synth_offset_trim_q;
      IDX_CARRIER_HIGH: rd_byte = base_full[23:16];
      IDX_CARRIER_MID: rd_byte = base_full[15:8];
      IDX_CARRIER_LOW: rd_byte = base_full[7:0];
      default: rd_byte = 8'h00;
    endcase
  end
  // Read data register, low byte only
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (ce_in && bus_req) begin
      wb_dat_out <= {24'h00_0000, rd_byte};
    end
  end
  // Register writes, byte lane 0
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      max_payload_size_q <= RST_PAYLOAD_LIMIT;
      preamble_quality_threshold_q <= RST_PQT;
      status_trailer_enable_q <= RST_TRAILER;
      address_filter_mode_q <= RST_ADDR_MODE;
      whitening_enable_q <= RST_WHITEN;
      packet_format_select_q <= RST_FORMAT;
      legacy_checksum_mode_q <= RST_LEGACY;
      crc_en_q <= RST_CRC_EN;
      len_mode_q <= RST_LEN_MODE;
      node_id_q <= RST_NODE_ID;
      rf_slot_index_q <= RST_SLOT;
      if_rsvd_q <= RST_IF_RSVD;
      intermediate_base_carrier_word_word_q <= RST_IF_WORD;
      synth_offset_trim_q <= RST_OFFSET;
      base_carrier_word_q <= {RST_CARRIER_HIGH, RST_CARRIER_MID, RST_CARRIER_LOW};
    end else if (ce_in && bus_wr) begin
      unique case (bus_idx)
        IDX_PAYLOAD_LIMIT: max_payload_size_q <= wb_dat_in[7:0];
        IDX_PKT_CTRL_A: begin
          preamble_quality_threshold_q <= wb_dat_in[7:5];
          status_trailer_enable_q <= wb_dat_in[2];
          address_filter_mode_q <= wb_dat_in[1:0];
        end
        IDX_PKT_CTRL_B: begin
          whitening_enable_q <= wb_dat_in[6];
          packet_format_select_q <= wb_dat_in[5:4];
          legacy_checksum_mode_q <= wb_dat_in[3];
          crc_en_q <= wb_dat_in[2];
          len_mode_q <= wb_dat_in[1:0];
        end
        IDX_NODE_ID: node_id_q <= wb_dat_in[7:0];
        IDX_SLOT_NUM: rf_slot_index_q <= wb_dat_in[7:0];
        IDX_IF_CTRL: begin
          if_rsvd_q <= wb_dat_in[5];
          intermediate_base_carrier_word_word_q <= wb_dat_in[4:0];
        end
        IDX_OFFSET_CTRL: synth_offset_trim_q <= wb_dat_in[7:0];
        IDX_CARRIER_HIGH: base_carrier_word_q[21:16] <= wb_dat_in[5:0];
        IDX_CARRIER_MID: base_carrier_word_q[15:8] <= wb_dat_in[7:0];
        IDX_CARRIER_LOW: base_carrier_word_q[7:0] <= wb_dat_in[7:0];
        default: ;
      endcase
    end
  end
  // Preamble quality counter, saturating both ways
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pq_count_q <= 5'h00;
      last_bit_q <= 1'b0;
      have_bit_q <= 1'b0;
    end else if (ce_in && rx_bit_valid_in) begin
      last_bit_q <= rx_bit_in;
      have_bit_q <= 1'b1;
      if (have_bit_q && (rx_bit_in != last_bit_q)) begin
        if (pq_count_q != PQ_MAX) begin
          pq_count_q <= pq_count_q + PQ_STEP_UP;
        end
      end else if (have_bit_q) begin
        if (pq_count_q > PQ_STEP_DOWN) begin
          pq_count_q <= pq_count_q - PQ_STEP_DOWN;
        end else begin
          pq_count_q <= 5'h00;
        end
      end
    end
  end
  // Sync gating by preamble quality
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_accept_out <= 1'b0;
    end else if (ce_in) begin
      sync_accept_out <= sync_seen_in && (pq_count_q >= pq_thr);
    end
  end
  // Address filter on first address byte
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_valid_out <= 1'b0;
      addr_accept_out <= 1'b0;
    end else if (ce_in) begin
      addr_valid_out <= rx_addr_valid_in;
      if (rx_addr_valid_in) begin
        unique case (address_filter_mode_q)
          ADDR_NONE: addr_accept_out <= 1'b1;
          ADDR_OWN: addr_accept_out <= (rx_addr_in == node_id_q);
          ADDR_BCAST0: addr_accept_out <= (rx_addr_in == node_id_q) ||
                                          (rx_addr_in == BCAST_LOW);
          ADDR_BCAST_BOTH: addr_accept_out <= (rx_addr_in == node_id_q) ||
                                              (rx_addr_in == BCAST_LOW) ||
                                              (rx_addr_in == BCAST_HIGH);
        endcase
      end
    end
  end
  // Packet length selection and cap
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      len_valid_out <= 1'b0;
      len_out <= 8'h00;
      len_error_out <= 1'b0;
    end else if (ce_in) begin
      len_valid_out <= rx_len_valid_in;
      if (rx_len_valid_in) begin
        if (len_mode_q == LEN_FIXED) begin
          len_out <= max_payload_size_q;
          len_error_out <= 1'b0;
        end else if (len_mode_q == LEN_VARIABLE) begin
          len_out <= rx_len_in;
          len_error_out <= (rx_len_in > max_payload_size_q);
        end else begin
          // Reserved modes refuse the packet
          len_out <= 8'h00;
          len_error_out <= 1'b1;
        end
      end
    end
  end
  // Status trailer bytes
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      trailer_enable_out <= RST_TRAILER;
      trailer_byte0_out <= 8'h00;
      trailer_byte1_out <= 8'h00;
    end else if (ce_in) begin
      // strength, then checksum flag and quality
      trailer_enable_out <= status_trailer_enable_q;
      trailer_byte0_out <= rssi_in;
      trailer_byte1_out <= {crc_ok_in, link_quality_value_in};
    end
  end
  // Whitening and checksum mode resolution
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      whiten_active_out <= RST_WHITEN & ~RST_LEGACY;
      legacy_crc_out <= RST_LEGACY & ~RST_WHITEN;
      crc_enable_out <= RST_CRC_EN;
    end else if (ce_in) begin
      whiten_active_out <= whitening_enable_q & ~legacy_checksum_mode_q;
      legacy_crc_out <= legacy_checksum_mode_q & ~whitening_enable_q;
      crc_enable_out <= crc_en_q;
    end
  end
  // Pseudo-random transmit generator
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pn9_q <= PN9_SEED;
      random_tx_out <= 1'b0;
      pn9_bit_out <= 1'b0;
    end else if (ce_in) begin
      random_tx_out <= (packet_format_select_q == FORMAT_RANDOM_TX) & ~rx_mode_in;
      if (packet_format_select_q != FORMAT_RANDOM_TX) begin
        pn9_q <= PN9_SEED;
      end else if (tx_bit_strobe_in && !rx_mode_in) begin
        pn9_bit_out <= pn9_q[0];
        pn9_q <= {pn9_q[0] ^ pn9_q[5], pn9_q[8:1]};
      end
    end
  end
  // Synthesizer word: base + slot*spacing + trim, minus IF in receive
  always_comb begin
    synth_d = base_full;
    synth_d = synth_d + 24'(rf_slot_index_q * rf_slot_index_spacing_in);
    synth_d = synth_d + 24'({{16{synth_offset_trim_q[7]}}, synth_offset_trim_q} << OFFSET_SHIFT);
    if (rx_mode_in) begin
      synth_d = synth_d - 24'({19'h0_0000, intermediate_base_carrier_word_word_q} << IF_SHIFT);
    end
  end
  // Synthesizer and mixer outputs
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      synth_word_out <= 24'h00_0000;
      if_mixer_out <= RST_IF_WORD;
    end else if (ce_in) begin
      synth_word_out <= synth_d;
      if_mixer_out <= intermediate_base_carrier_word_word_q;
    end
  end
  // Checks
  chk_pq_step_up: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && rx_bit_valid_in && have_bit_q && rx_bit_in != last_bit_q && pq_count_q < PQ_MAX)
    |=> pq_count_q == $past(pq_count_q) + PQ_STEP_UP)
    else $error("quality counter did not step up");
  chk_pq_step_down: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && rx_bit_valid_in && have_bit_q && rx_bit_in == last_bit_q && pq_count_q > PQ_STEP_DOWN)
    |=> pq_count_q == $past(pq_count_q) - PQ_STEP_DOWN)
    else $error("quality counter did not step down");
  chk_sync_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && sync_seen_in && preamble_quality_threshold_q == 3'h0) |=> sync_accept_out)
    else $error("sync refused with zero threshold");
  chk_trailer_bytes: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ce_in |=> trailer_byte1_out == {$past(crc_ok_in), $past(link_quality_value_in)})
    else $error("trailer byte wrong");
  chk_addr_own: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && rx_addr_valid_in && address_filter_mode_q == ADDR_OWN && rx_addr_in != node_id_q)
    |=> addr_valid_out && !addr_accept_out)
    else $error("foreign address accepted");
  chk_addr_bcast: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && rx_addr_valid_in && address_filter_mode_q == ADDR_BCAST_BOTH && rx_addr_in == BCAST_HIGH)
    |=> addr_accept_out)
    else $error("broadcast address refused");
  chk_white_legacy: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !(whiten_active_out && legacy_crc_out))
    else $error("whitening with legacy checksum");
  chk_len_cap: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && rx_len_valid_in && len_mode_q == LEN_VARIABLE && rx_len_in > max_payload_size_q)
    |=> len_valid_out && len_error_out)
    else $error("oversize length not flagged");
  chk_len_fixed: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && rx_len_valid_in && len_mode_q == LEN_FIXED) |=> len_out == $past(max_payload_size_q))
    else $error("fixed length not used");
  chk_wb_ack: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && bus_req) |=> wb_ack_out ##1 !wb_ack_out || !$past(ce_in))
    else $error("ack not a single pulse");

endmodule // radio_pkt_core

// File: core/radio_pkt_pkg.sv
package radio_pkt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_PAYLOAD_LIMIT = 16'hdf02;
  localparam logic [15:0] IDX_PKT_CTRL_A = 16'hdf03;
  localparam logic [15:0] IDX_PKT_CTRL_B = 16'hdf04;
  localparam logic [15:0] IDX_NODE_ID = 16'hdf05;
  localparam logic [15:0] IDX_SLOT_NUM = 16'hdf06;
  localparam logic [15:0] IDX_IF_CTRL = 16'hdf07;
  localparam logic [15:0] IDX_OFFSET_CTRL = 16'hdf08;
  localparam logic [15:0] IDX_CARRIER_HIGH = 16'hdf09;
  localparam logic [15:0] IDX_CARRIER_MID = 16'hdf0a;
  localparam logic [15:0] IDX_CARRIER_LOW = 16'hdf0b;
  // Reset values
  localparam logic [7:0] RST_PAYLOAD_LIMIT = 8'hff;
  localparam logic [2:0] RST_PQT = 3'h0;
  localparam logic RST_TRAILER = 1'b1;
  localparam logic [1:0] RST_ADDR_MODE = 2'h0;
  localparam logic RST_WHITEN = 1'b1;
  localparam logic [1:0] RST_FORMAT = 2'h0;
  localparam logic RST_LEGACY = 1'b0;
  localparam logic RST_CRC_EN = 1'b1;
  localparam logic [1:0] RST_LEN_MODE = 2'h1;
  localparam logic [7:0] RST_NODE_ID = 8'h00;
  localparam logic [7:0] RST_SLOT = 8'h00;
  localparam logic RST_IF_RSVD = 1'b0;
  localparam logic [4:0] RST_IF_WORD = 5'h0f;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [1:0] CARRIER_TOP_RO = 2'h1;
  localparam logic [5:0] RST_CARRIER_HIGH = 6'h1e;
  localparam logic [7:0] RST_CARRIER_MID = 8'hc4;
  localparam logic [7:0] RST_CARRIER_LOW = 8'hec;
  // Address filter modes
  localparam logic [1:0] ADDR_NONE = 2'h0;
  localparam logic [1:0] ADDR_OWN = 2'h1;
  localparam logic [1:0] ADDR_BCAST0 = 2'h2;
  localparam logic [1:0] ADDR_BCAST_BOTH = 2'h3;
  localparam logic [7:0] BCAST_LOW = 8'h00;
  localparam logic [7:0] BCAST_HIGH = 8'hff;
  // Packet format and length modes
  localparam logic [1:0] FORMAT_RANDOM_TX = 2'h2;
  localparam logic [1:0] LEN_FIXED = 2'h0;
  localparam logic [1:0] LEN_VARIABLE = 2'h1;
  // Preamble quality counter
  localparam logic [4:0] PQ_MAX = 5'h1f;
  localparam logic [4:0] PQ_STEP_UP = 5'h01;
  localparam logic [4:0] PQ_STEP_DOWN = 5'h08;
  localparam int PQ_THR_SHIFT = 2;
  // Scaling of offset and IF into base word units (x4 and x64 steps)
  localparam int OFFSET_SHIFT = 2;
  localparam int IF_SHIFT = 6;
  // Pseudo-random generator seed
  localparam logic [8:0] PN9_SEED = 9'h1ff;
endpackage

// File: bench/radio_peer_model.sv
`timescale 1ns/10ps
// Far-side radio: received bits, sync, header bytes, trailer levels
module radio_peer_model (
  input wire logic sys_clk_in,
  output logic bit_valid_out,
  output logic bit_out,
  output logic sync_out,
  output logic addr_valid_out,
  output logic [7:0] addr_out,
  output logic len_valid_out,
  output logic [7:0] len_out,
  output logic [7:0] rssi_out,
  output logic [6:0] lqi_out,
  output logic crc_ok_out,
  output logic tx_strobe_out
);
  // Quiet lines at time zero
  initial begin
    {bit_valid_out, bit_out, sync_out, addr_valid_out, len_valid_out, tx_strobe_out} = '0;
    {addr_out, len_out, rssi_out, lqi_out, crc_ok_out} = '0;
  end
  // One event: 0 bit, 1 sync, 2 address, 3 length, else tx strobe
  task automatic send(input logic [2:0] kind, input logic [7:0] v);
    @(posedge sys_clk_in);
    case (kind)
      3'd0: begin
        bit_valid_out <= 1'b1;
        bit_out <= v[0];
      end
      3'd1: sync_out <= 1'b1;
      3'd2: begin
        addr_valid_out <= 1'b1;
        addr_out <= v;
      end
      3'd3: begin
        len_valid_out <= 1'b1;
        len_out <= v;
      end
      default: tx_strobe_out <= 1'b1;
    endcase
    @(posedge sys_clk_in);
    // Strobes last one cycle; released data shows the inverse
    {bit_valid_out, sync_out, addr_valid_out, len_valid_out, tx_strobe_out} <= '0;
    bit_out <= ~v[0];
    addr_out <= ~v;
    len_out <= ~v;
  endtask
  // Trailer levels: checksum flag, link quality, strength
  task automatic levels(input logic [15:0] v);
    @(posedge sys_clk_in);
    {crc_ok_out, lqi_out, rssi_out} <= v;
  endtask
endmodule // radio_peer_model

// File: bench/radio_packet_and_synth_config_test.sv
`timescale 1ns/10ps
// Self-checking bench: register map, stream filters, frequency word
module radio_packet_and_synth_config_test
  import radio_pkt_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [17:0] wb_adr_in = '0;
  logic [3:0] wb_sel_in = 4'h1;
  logic [31:0] wb_dat_in = '0;
  logic rx_mode_in = 1'b0;
  logic [15:0] rf_slot_index_spacing_in = '0;
  logic [31:0] wb_dat_out;
  logic wb_ack_out, rx_bit_valid_in, rx_bit_in, sync_seen_in, rx_addr_valid_in;
  logic [7:0] rx_addr_in, rx_len_in, rssi_in, len_out, trailer_byte0_out, trailer_byte1_out;
  logic rx_len_valid_in, crc_ok_in, tx_bit_strobe_in, sync_accept_out, addr_valid_out;
  logic addr_accept_out, len_valid_out, len_error_out, trailer_enable_out, whiten_active_out;
  logic legacy_crc_out, crc_enable_out, random_tx_out, pn9_bit_out;
  logic [6:0] link_quality_value_in;
  logic [4:0] if_mixer_out;
  logic [23:0] synth_word_out;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rng = 32'he0b3b555;
  logic [31:0] q_rd[$];
  logic q_acc[$];
  logic [8:0] q_len[$];
  logic [7:0] rst_v [10] = '{RST_PAYLOAD_LIMIT, {RST_PQT, 2'b00, RST_TRAILER, RST_ADDR_MODE},
    {1'b0, RST_WHITEN, RST_FORMAT, RST_LEGACY, RST_CRC_EN, RST_LEN_MODE}, RST_NODE_ID,
    RST_SLOT, {2'b00, RST_IF_RSVD, RST_IF_WORD}, RST_OFFSET,
    {CARRIER_TOP_RO, RST_CARRIER_HIGH}, RST_CARRIER_MID, RST_CARRIER_LOW};
  logic [7:0] wmask [10] = '{8'hff, 8'he7, 8'h7f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'hff};

  // Clock at 25 MHz
  initial forever #20 sys_clk_in = ~sys_clk_in;

  radio_pkt_core uut (
    .sys_clk_in, .rst_in, .ce_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_dat_out, .wb_ack_out, .rx_bit_valid_in, .rx_bit_in, .sync_seen_in,
    .rx_addr_valid_in, .rx_addr_in, .rx_len_valid_in, .rx_len_in, .rssi_in,
    .link_quality_value_in, .crc_ok_in, .tx_bit_strobe_in, .rx_mode_in, .rf_slot_index_spacing_in,
    .sync_accept_out, .addr_valid_out, .addr_accept_out, .len_valid_out, .len_out,
    .len_error_out, .trailer_enable_out, .trailer_byte0_out, .trailer_byte1_out,
    .whiten_active_out, .legacy_crc_out, .crc_enable_out, .random_tx_out, .pn9_bit_out,
    .if_mixer_out, .synth_word_out
  );

  radio_peer_model peer (
    .sys_clk_in, .bit_valid_out(rx_bit_valid_in), .bit_out(rx_bit_in),
    .sync_out(sync_seen_in), .addr_valid_out(rx_addr_valid_in), .addr_out(rx_addr_in),
    .len_valid_out(rx_len_valid_in), .len_out(rx_len_in), .rssi_out(rssi_in),
    .lqi_out(link_quality_value_in), .crc_ok_out(crc_ok_in), .tx_strobe_out(tx_bit_strobe_in)
  );

  // Xorshift source
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Value comparison
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Flag comparison
  task automatic chk_flag(input logic got, input logic exp, input string what);
    chk_word({31'h0, got}, {31'h0, exp}, what);
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
                     input logic [3:0] s);
    @(posedge sys_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_sel_in <= s;
    wb_adr_in <= {idx, 2'b00};
    wb_dat_in <= {24'hffffff, d};
    do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask

  // Read, with the expected byte noted first
  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    q_rd.push_back({24'h0, e});
    bus(1'b0, idx, 8'h00, 4'h1);
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk_in);
  endtask

  // Sync word offered; accept flag seen one cycle later
  task automatic sync_chk(input logic e);
    peer.send(3'd1, 8'h00);
    @(posedge sys_clk_in);
    chk_flag(sync_accept_out, e, "sync");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watcher: each answer takes the oldest note
  always @(posedge sys_clk_in) begin
    if (wb_ack_out && !wb_we_in)
      chk_word(wb_dat_out, q_rd.size() ? q_rd.pop_front() : 'x, "read");
    if (addr_valid_out)
      chk_flag(addr_accept_out, q_acc.size() ? q_acc.pop_front() : 1'bx, "filter");
    if (len_valid_out)
      chk_word({len_error_out, len_out}, q_len.size() ? q_len.pop_front() : 'x, "len");
  end

  // Hang limit
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 10000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] r, r2, ones;
    logic [23:0] e;
    logic [7:0] node, lim, av;
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    // Reset values, unmapped places, ignored byte lane
    for (int i = 0; i < 10; i++) rd(16'hdf02 + 16'(i), rst_v[i]);
    wr(16'hdf0c, 8'hff);
    rd(16'hdf0c, 8'h00);
    rd(16'hdf01, 8'h00);
    bus(1'b1, IDX_NODE_ID, 8'h5a, 4'h0);
    rd(IDX_NODE_ID, RST_NODE_ID);
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      wr(16'hdf02 + 16'(i), r[7:0]);
      rd(16'hdf02 + 16'(i), (r[7:0] & wmask[i]) | (rst_v[i] & ~wmask[i]));
    end
    $display("registers done");
    for (int k = 0; k < 32; k++) begin
      wr(IDX_PKT_CTRL_B, {1'b0, k[0], k[4:3], k[1], k[2], 2'b01});
      settle();
      e = {20'h0, k[0] & ~k[1], k[1] & ~k[0], k[2], k[4:3] == 2'b10};
      chk_word({whiten_active_out, legacy_crc_out, crc_enable_out, random_tx_out}, e, "modes");
    end
    $display("modes done");
    r = rnd();
    node = {1'b0, r[6:1], 1'b1};
    wr(IDX_NODE_ID, node);
    for (int m = 0; m < 4; m++) begin
      r = rnd();
      wr(IDX_PKT_CTRL_A, {5'h00, m[0], m[1:0]});
      peer.levels(r[15:0]);
      settle();
      chk_word({trailer_enable_out, trailer_byte1_out, trailer_byte0_out}, {m[0], r[15:0]}, "trailer");
      for (int a = 0; a < 4; a++) begin
        av = a == 0 ? node : a == 1 ? BCAST_LOW : a == 2 ? BCAST_HIGH : node ^ 8'h40;
        q_acc.push_back(m == 0 || av == node || (m >= 2 && av == 8'h00) || (m == 3 && av == 8'hff));
        peer.send(3'd2, av);
      end
    end
    $display("filter done");
    r = rnd();
    lim = {2'b01, r[5:0]};
    wr(IDX_PAYLOAD_LIMIT, lim);
    // Pass four repeats variable mode with a length above the cap
    for (int m = 0; m < 5; m++) begin
      wr(IDX_PKT_CTRL_B, {6'h01, m == 4 ? 2'b01 : m[1:0]});
      av = m == 4 ? {1'b1, r[14:8]} : {2'b00, r[13:8]};
      q_len.push_back(m == 0 ? {1'b0, lim} : m == 1 || m == 4 ? {m[2], av} : 9'h100);
      peer.send(3'd3, av);
    end
    $display("length done");
    wr(IDX_PKT_CTRL_A, 8'h60);
    peer.send(3'd0, 8'h00);
    peer.send(3'd0, 8'h00);
    for (int j = 1; j <= 11; j++) peer.send(3'd0, 8'(j & 1));
    sync_chk(1'b0);
    peer.send(3'd0, 8'h00);
    sync_chk(1'b1);
    peer.send(3'd0, 8'h00);
    sync_chk(1'b0);
    for (int j = 1; j <= 40; j++) peer.send(3'd0, 8'(j & 1));
    peer.send(3'd0, 8'h00);
    wr(IDX_PKT_CTRL_A, 8'hc0);
    sync_chk(1'b0);
    wr(IDX_PKT_CTRL_A, 8'ha0);
    sync_chk(1'b1);
    wr(IDX_PKT_CTRL_A, 8'h00);
    sync_chk(1'b1);
    $display("preamble done");
    // Random transmit: one full generator period
    wr(IDX_PKT_CTRL_B, 8'h21);
    ones = '0;
    repeat (511) begin
      peer.send(3'd4, 8'h00);
      @(posedge sys_clk_in);
      ones = ones + {31'h0, pn9_bit_out};
    end
    chk_word(ones, 32'h100, "pn9 ones");
    $display("random done");
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      r2 = rnd();
      wr(IDX_SLOT_NUM, r[7:0]);
      wr(IDX_OFFSET_CTRL, r[15:8]);
      wr(IDX_IF_CTRL, r[23:16]);
      wr(IDX_CARRIER_HIGH, r2[7:0]);
      wr(IDX_CARRIER_MID, r2[15:8]);
      wr(IDX_CARRIER_LOW, r2[23:16]);
      rf_slot_index_spacing_in <= r2[31:16] ^ r[31:16];
      rx_mode_in <= k[0];
      settle();
      e = {CARRIER_TOP_RO, r2[5:0], r2[15:8], r2[23:16]} + r[7:0] * (r2[31:16] ^ r[31:16]);
      e = e + {{14{r[15]}}, r[15:8], 2'b00} - (k[0] ? {13'h0, r[20:16], 6'h00} : 24'h0);
      chk_word({8'h00, synth_word_out}, {8'h00, e}, "synth");
      chk_word({27'h0, if_mixer_out}, {27'h0, r[20:16]}, "mixer");
      chk_flag(random_tx_out, ~k[0], "random in receive");
    end
    // Clock enable low: outputs hold although inputs move
    ce_in <= 1'b0;
    rx_mode_in <= 1'b0;
    peer.send(3'd2, 8'h00);
    settle();
    chk_word({8'h00, synth_word_out}, {8'h00, e}, "frozen synth");
    chk_flag(addr_valid_out, 1'b0, "frozen filter");
    ce_in <= 1'b1;
    $display("synth done");
    chk_word(q_rd.size() + q_acc.size() + q_len.size(), 0, "unanswered");
    tally_and_finish();
  end
endmodule // radio_packet_and_synth_config_test
